// ### rtl/dtb_defines.svh
// Constants for the data transfer bus slave responder and bus timer.
`ifndef DTB_DEFINES_SVH
`define DTB_DEFINES_SVH

// Local clock rate in MHz (10 ns period).
`define DTB_CLK_MHZ 100
// Bus time-out period in microseconds, as printed in the timer's rating.
`define DTB_BTO_US 64
// Time-out period as a count of local clock cycles.
`define DTB_BTO_CYCLES (`DTB_BTO_US * `DTB_CLK_MHZ)

// Address modifier field that tells the addressing mode apart.
`define DTB_AM_MODE_MSB 5
`define DTB_AM_MODE_LSB 4
`define DTB_AM_SHORT 2'h2
`define DTB_AM_STD 2'h3
`define DTB_AM_EXT 2'h0

// Reset values.
`define DTB_DATA_RST 32'h0000_0000
`define DTB_ADDR_RST 31'h0000_0000
`define DTB_AM_RST 6'h00

`endif

// ### rtl/dtb_pkg.sv
// Types shared by the data transfer bus slave responder and bus timer.
package dtb_pkg;

   // Cycle kinds told apart by the strobes, A01 and LWORD.
   typedef enum logic [2:0] {
      CK_ADDR_ONLY = 3'b000,
      CK_SINGLE_ODD = 3'b001,
      CK_SINGLE_EVEN = 3'b010,
      CK_DOUBLE = 3'b011,
      CK_QUAD = 3'b100,
      CK_UNALIGNED = 3'b101
   } cycle_kind_t;

   // Addressing modes carried by the address modifier.
   typedef enum logic [1:0] {
      AMODE_NONE = 2'b00,
      AMODE_SHORT = 2'b01,
      AMODE_STD = 2'b10,
      AMODE_EXT = 2'b11
   } addr_mode_t;

   // Data width capability of the slave.
   typedef enum logic [1:0] {
      DW_D08_ODD = 2'b00,
      DW_D08_EO = 2'b01,
      DW_D16 = 2'b10,
      DW_D32 = 2'b11
   } data_width_t;

   // Slave response sequence.
   typedef enum logic [2:0] {
      RS_IDLE = 3'b000,
      RS_DECIDE = 3'b001,
      RS_LOCAL = 3'b010,
      RS_PLACE = 3'b011,
      RS_HOLD = 3'b100
   } resp_state_t;

endpackage

// ### rtl/dtb_cycle_decoder.sv
// Cycle kind and addressing mode decoder for a captured bus cycle.
`timescale 1ns/1ps

module dtb_cycle_decoder
   import dtb_pkg::*;
(
   // Captured cycle
   input wire logic [1:0] ds_n,
   input wire logic a01,
   input wire logic lword_n,
   input wire logic [5:0] am,
   // Decoded cycle
   output cycle_kind_t kind,
   output addr_mode_t mode
);

   `include "dtb_defines.svh"

   logic [1:0] am_mode;

   assign am_mode = am[`DTB_AM_MODE_MSB:`DTB_AM_MODE_LSB];

   // Address-only plus the data cycle kinds, under every addressing mode.
   always_comb
   begin
      kind = CK_ADDR_ONLY;
      if (ds_n == 2'b11)
         kind = CK_ADDR_ONLY;
      else if (ds_n == 2'b00)
      begin
         if (!lword_n)
            kind = a01 ? CK_UNALIGNED : CK_QUAD;
         else
            kind = CK_DOUBLE;
      end
      else if (!lword_n)
         kind = a01 ? CK_ADDR_ONLY : CK_UNALIGNED;
      else if (!ds_n[0])
         kind = CK_SINGLE_ODD;
      else
         kind = CK_SINGLE_EVEN;
   end

   always_comb
   begin
      mode = AMODE_NONE;
      if (am_mode == `DTB_AM_SHORT)
         mode = AMODE_SHORT;
      else if (am_mode == `DTB_AM_STD)
         mode = AMODE_STD;
      else if (am_mode == `DTB_AM_EXT)
         mode = AMODE_EXT;
   end

endmodule // dtb_cycle_decoder

// ### rtl/dtb_bus_timer.sv
// Bus timer that raises bus error when the first data strobe stays low too long.
`timescale 1ns/1ps

module dtb_bus_timer
   import dtb_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = 6400,
   parameter bit CHECK_LINES = 1'b0
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Bus lines seen by the timer
   input wire logic strobe_low,
   input wire logic dtack_n,
   input wire logic berr_n,
   // Time-out request
   output logic fire
);

   localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
   localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT_CYCLES);

   typedef struct packed {
      logic [CW-1:0] count;
      logic fire;
   } timer_state_t;

   timer_state_t st;
   timer_state_t next_st;

   generate
      if (TIMEOUT_CYCLES < 2)
      begin : g_bad_timeout
         $error("Bus timer needs a time-out of at least two cycles.");
      end
   endgenerate

   always_comb
   begin
      next_st = st;
      if (!strobe_low)
      begin
         next_st.count = '0;
         next_st.fire = 1'b0;
      end
      else if (st.count != LIMIT)
         next_st.count = st.count + CW'(1);
      else if (!st.fire && (!CHECK_LINES || (dtack_n && berr_n)))
         next_st.fire = 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         st <= '0;
      else if (ce)
         st <= next_st;
   end

   assign fire = st.fire;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !ce);

   AST_TIMER_FIRES: assert property (
      (strobe_low && st.count == LIMIT && !st.fire && (!CHECK_LINES || (dtack_n && berr_n)))
      |=> fire)
      else $error("Timer did not fire at time-out.");

   AST_TIMER_RESTART: assert property (
      !strobe_low |=> (st.count == '0 && !fire))
      else $error("Timer did not restart on strobe release.");

   AST_TIMER_NO_EARLY: assert property (
      $rose(fire) |-> ($past(st.count) == LIMIT && $past(strobe_low)))
      else $error("Timer fired before the time-out.");

endmodule // dtb_bus_timer

// ### rtl/dtb_slave_response_bus_timer.sv
// Data transfer bus slave responder with bus timer.
`timescale 1ns/1ps

module dtb_slave_response_bus_timer
   import dtb_pkg::*;
#(
   parameter data_width_t DATA_CAP = DW_D32,
   parameter bit UAT_CAP = 1'b0,
   parameter bit HAS_BERR = 1'b1,
   parameter bit WATCH_AS = 1'b0,
   parameter bit A16_EN = 1'b1,
   parameter bit A24_EN = 1'b1,
   parameter bit A32_EN = 1'b1,
   parameter logic [31:0] BASE_A16 = 32'h0000_0000,
   parameter logic [31:0] BASE_A24 = 32'h0000_0000,
   parameter logic [31:0] BASE_A32 = 32'h0000_0000,
   parameter int unsigned WIN_BITS = 12,
   parameter bit TIMER_EN = 1'b1,
   parameter bit TIMER_CHECK_LINES = 1'b0,
   parameter int unsigned BTO_CYCLES = `DTB_BTO_CYCLES
)
(
   // Clock, reset and enable
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic CE,
   // Bus inputs
   input wire logic AS_N,
   input wire logic DS0_N,
   input wire logic DS1_N,
   input wire logic LWORD_N,
   input wire logic WRITE_N,
   input wire logic IACK_N,
   input wire logic [31:1] A,
   input wire logic [5:0] AM,
   input wire logic [31:0] D_IN,
   // Open-drain acknowledge and error lines
   input wire logic DTACK_N_IN,
   output logic DTACK_N_OUT,
   output logic DTACK_OE,
   input wire logic BERR_N_IN,
   output logic BERR_N_OUT,
   output logic BERR_OE,
   // Data drivers, one enable per byte lane
   output logic [31:0] D_OUT,
   output logic [3:0] D_OE,
   // Local storage side
   output logic LOC_REQ,
   output logic LOC_WRITE,
   output logic [31:1] LOC_ADDR,
   output logic [1:0] LOC_DS_N,
   output logic LOC_LWORD_N,
   output logic [31:0] LOC_WDATA,
   input wire logic LOC_ACK,
   input wire logic [31:0] LOC_RDATA,
   input wire logic LOC_RERR
);

   `include "dtb_defines.svh"

   typedef struct packed {
      resp_state_t state;
      logic [31:1] addr;
      logic [5:0] am;
      logic write;
      logic lword_n;
      logic [1:0] ds_n;
      logic [31:0] wdata;
      logic loc_req;
      logic dtack_oe;
      logic berr_oe;
      logic [31:0] dout;
      logic [3:0] d_oe;
   } slave_state_t;

   slave_state_t st;
   slave_state_t next_st;
   cycle_kind_t kind;
   addr_mode_t mode;
   logic strobe_low;
   logic timer_fire;
   logic selected;
   logic reject;
   logic [31:0] full_addr;
   logic [3:0] lane_mask;
   logic [31:0] data_mask;
   logic quad_ok;
   logic double_ok;

   localparam logic [31:0] WIN_MASK = ~((32'h0000_0001 << WIN_BITS) - 32'h0000_0001);

   generate
      if (WIN_BITS < 1 || WIN_BITS > 15)
      begin : g_bad_window
         $error("Window bits must lie between 1 and 15.");
      end
      if (!A16_EN && !A24_EN && !A32_EN)
      begin : g_no_mode
         $error("At least one addressing mode must be enabled.");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Cycle decode and capability checks.

   dtb_cycle_decoder i_dtb_cycle_decoder (
      .ds_n(st.ds_n),
      .a01(st.addr[1]),
      .lword_n(st.lword_n),
      .am(st.am),
      .kind(kind),
      .mode(mode)
   );

   assign strobe_low = !DS0_N || !DS1_N;
   assign full_addr = {st.addr, 1'b0};
   assign quad_ok = (DATA_CAP == DW_D32);
   assign double_ok = (DATA_CAP == DW_D16) || (DATA_CAP == DW_D32);

   // Lanes that this width monitors and drives.
   always_comb
   begin
      lane_mask = 4'h1;
      if (DATA_CAP == DW_D16)
         lane_mask = 4'h3;
      else if (DATA_CAP == DW_D32)
         lane_mask = 4'hF;
      data_mask = {{8{lane_mask[3]}}, {8{lane_mask[2]}}, {8{lane_mask[1]}}, {8{lane_mask[0]}}};
   end

   // Address decode per mode, upper lines above the mode's width ignored.
   always_comb
   begin
      selected = 1'b0;
      unique case (mode)
         AMODE_SHORT:
            selected = A16_EN && (((full_addr ^ BASE_A16) & WIN_MASK & 32'h0000_FFFF) == 32'h0000_0000);
         AMODE_STD:
            selected = A24_EN && (((full_addr ^ BASE_A24) & WIN_MASK & 32'h00FF_FFFF) == 32'h0000_0000);
         AMODE_EXT:
            selected = A32_EN && (((full_addr ^ BASE_A32) & WIN_MASK) == 32'h0000_0000);
         AMODE_NONE:
            selected = 1'b0;
      endcase
      if (kind == CK_ADDR_ONLY)
         selected = 1'b0;
      if (DATA_CAP == DW_D08_ODD && kind == CK_SINGLE_EVEN)
         selected = 1'b0;
   end

   always_comb
   begin
      reject = 1'b0;
      if (kind == CK_QUAD && !quad_ok)
         reject = 1'b1;
      if (kind == CK_DOUBLE && !double_ok)
         reject = 1'b1;
      if (kind == CK_UNALIGNED && !UAT_CAP)
         reject = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus timer.

   generate
      if (TIMER_EN)
      begin : g_timer
         dtb_bus_timer #(
            .TIMEOUT_CYCLES(BTO_CYCLES),
            .CHECK_LINES(TIMER_CHECK_LINES)
         ) i_dtb_bus_timer (
            .clk(SYS_CLK),
            .rst(RST),
            .ce(CE),
            .strobe_low(strobe_low),
            .dtack_n(DTACK_N_IN),
            .berr_n(BERR_N_IN),
            .fire(timer_fire)
         );
      end
      else
      begin : g_no_timer
         assign timer_fire = 1'b0;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Response sequence.

   always_comb
   begin
      next_st = st;
      next_st.berr_oe = 1'b0;
      unique case (st.state)
         RS_IDLE:
         begin
            // Capture on the first strobe edge; the address strobe is optional.
            if (strobe_low && IACK_N && (!WATCH_AS || !AS_N))
            begin
               next_st.addr = A;
               next_st.am = AM;
               next_st.write = !WRITE_N;
               next_st.lword_n = LWORD_N;
               next_st.ds_n = {DS1_N, DS0_N};
               next_st.wdata = D_IN & data_mask;
               next_st.state = RS_DECIDE;
            end
         end
         RS_DECIDE:
         begin
            if (!selected)
               next_st.state = RS_HOLD;
            else if (reject)
            begin
               next_st.berr_oe = HAS_BERR;
               next_st.state = RS_HOLD;
            end
            else
            begin
               next_st.loc_req = 1'b1;
               next_st.state = RS_LOCAL;
            end
         end
         RS_LOCAL:
         begin
            if (LOC_ACK)
            begin
               next_st.loc_req = 1'b0;
               next_st.state = RS_HOLD;
               if (!strobe_low)
                  next_st.state = RS_IDLE;
               else if (!st.write && LOC_RERR)
                  next_st.berr_oe = HAS_BERR;
               else if (st.write)
                  next_st.dtack_oe = 1'b1;
               else
               begin
                  next_st.dout = LOC_RDATA & data_mask;
                  next_st.d_oe = lane_mask;
                  next_st.state = RS_PLACE;
               end
            end
         end
         RS_PLACE:
         begin
            next_st.dtack_oe = 1'b1;
            next_st.state = RS_HOLD;
         end
         RS_HOLD:
         begin
            // Responses stand until the master lets both strobes go.
            next_st.berr_oe = st.berr_oe;
            if (!strobe_low)
            begin
               next_st.dtack_oe = 1'b0;
               next_st.berr_oe = 1'b0;
               next_st.d_oe = 4'h0;
               next_st.state = RS_IDLE;
            end
         end
         default:
            next_st.state = RS_IDLE;
      endcase
      if (timer_fire && strobe_low)
         next_st.berr_oe = 1'b1;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         st <= '0;
         st.state <= RS_IDLE;
         st.addr <= `DTB_ADDR_RST;
         st.am <= `DTB_AM_RST;
         st.ds_n <= 2'b11;
         st.lword_n <= 1'b1;
         st.wdata <= `DTB_DATA_RST;
         st.dout <= `DTB_DATA_RST;
      end
      else if (CE)
         st <= next_st;
   end

   // Open-drain lines pull low while enabled.
   assign DTACK_OE = st.dtack_oe;
   assign DTACK_N_OUT = 1'b0;
   assign BERR_OE = st.berr_oe;
   assign BERR_N_OUT = 1'b0;
   assign D_OUT = st.dout;
   assign D_OE = st.d_oe;
   assign LOC_REQ = st.loc_req;
   assign LOC_WRITE = st.write;
   assign LOC_ADDR = st.addr;
   assign LOC_DS_N = st.ds_n;
   assign LOC_LWORD_N = st.lword_n;
   assign LOC_WDATA = st.wdata;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST || !CE);

   sequence s_reject_seen;
      st.state == RS_DECIDE && selected && reject;
   endsequence

   sequence s_read_error;
      st.state == RS_LOCAL && LOC_ACK && !st.write && LOC_RERR && strobe_low;
   endsequence

   AST_NO_ACK_QUAD: assert property (
      (st.state != RS_IDLE && kind == CK_QUAD && !quad_ok) |-> !DTACK_OE)
      else $error("Quad cycle acknowledged without quad capability.");

   AST_NO_ACK_DOUBLE: assert property (
      (st.state != RS_IDLE && kind == CK_DOUBLE && !double_ok) |-> !DTACK_OE)
      else $error("Double cycle acknowledged by a byte-only slave.");

   AST_NO_ACK_UNALIGNED: assert property (
      (st.state != RS_IDLE && kind == CK_UNALIGNED && !UAT_CAP) |-> !DTACK_OE)
      else $error("Unaligned cycle acknowledged without capability.");

   AST_REJECT_ERROR: assert property (
      s_reject_seen |=> (BERR_OE == HAS_BERR || timer_fire) && !DTACK_OE)
      else $error("Rejected cycle did not raise bus error.");

   AST_READ_ERROR: assert property (
      s_read_error |=> (BERR_OE == HAS_BERR || timer_fire) && !DTACK_OE && D_OE == 4'h0)
      else $error("Uncorrectable read did not raise bus error.");

   AST_NO_DRIVER: assert property (
      $rose(BERR_OE) |-> ($past(timer_fire) ||
         (HAS_BERR && ($past(st.state) == RS_DECIDE || $past(st.state) == RS_LOCAL))))
      else $error("Bus error driven by a slave without a driver.");

   AST_DATA_BEFORE_ACK: assert property (
      ($rose(DTACK_OE) && !LOC_WRITE) |-> $past(D_OE) == lane_mask)
      else $error("Read acknowledged before data was placed.");

   AST_IACK_IGNORED: assert property (
      (st.state == RS_IDLE && !IACK_N) |=> st.state == RS_IDLE)
      else $error("Cycle taken while interrupt acknowledge was low.");

   AST_RELEASE: assert property (
      (st.state == RS_HOLD && !strobe_low && !timer_fire) |=> !DTACK_OE && !BERR_OE && D_OE == 4'h0)
      else $error("Bus drivers held after strobe release.");

endmodule // dtb_slave_response_bus_timer

// ### verification/dtb_master_model.sv
// Bus master model that runs one data transfer cycle per call.
`timescale 1ns/1ps

module dtb_master_model
(
   // Clock and answer lines
   input wire logic clk,
   input wire logic dtack_n,
   input wire logic berr_n,
   input wire logic [31:0] d_bus,
   // Driven bus lines
   output logic as_n,
   output logic ds0_n,
   output logic ds1_n,
   output logic lword_n,
   output logic write_n,
   output logic iack_n,
   output logic [31:1] a,
   output logic [5:0] am,
   output logic [31:0] d
);
   initial
   begin
      as_n = 1'b1;
      ds0_n = 1'b1;
      ds1_n = 1'b1;
      lword_n = 1'b1;
      write_n = 1'b1;
      iack_n = 1'b1;
      a = 31'h0000_0000;
      am = 6'h00;
      d = 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // The whole address and direction are set a cycle before the strobes fall.
   task automatic run(input logic wr_n, input logic [1:0] ds, input logic lw, input logic [31:0] adr,
      input logic [5:0] mode, input logic ia, input logic [31:0] wd, output logic [31:0] rd,
      output logic err, output int n);
      n = 0;
      @(posedge clk);
      a <= adr[31:1];
      am <= mode;
      write_n <= wr_n;
      lword_n <= lw;
      iack_n <= ia;
      as_n <= 1'b0;
      d <= wd;
      @(posedge clk);
      {ds1_n, ds0_n} <= ds;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (dtack_n && berr_n && n < 300);
      rd = d_bus;
      err = !berr_n;
      {ds1_n, ds0_n} <= 2'b11;
      as_n <= 1'b1;
      iack_n <= 1'b1;
      a <= ~adr[31:1];
      d <= ~wd;
      for (int i = 0; i < 50 && !(dtack_n && berr_n); i++)
         @(posedge clk);
      @(posedge clk);
   endtask
endmodule // dtb_master_model

// ### verification/dtb_slave_response_bus_timer_tb_top.sv
// Testbench for the data transfer bus slave responder and bus timer.
`timescale 1ns/1ps

module dtb_slave_response_bus_timer_tb_top;
   import dtb_pkg::*;
   localparam int unsigned BTO = 16;
   logic sys_clk, rst, ce, as_n, ds0_n, ds1_n, lword_n, write_n, iack_n;
   logic [31:1] a;
   logic [5:0] am;
   logic [31:0] m_d, d_bus, d_out, loc_rdata, cap_wdata;
   logic dtack_n_out, dtack_oe, berr_n_out, berr_oe, dtack_n, berr_n;
   logic [3:0] d_oe;
   logic loc_req, loc_write, loc_lword_n, rerr_mode;
   logic loc_ack = 1'b0, loc_rerr = 1'b0, cap_write = 1'b0;
   logic [31:1] loc_addr;
   logic [31:1] cap_addr = 31'h0000_0000;
   logic [1:0] loc_ds_n;
   int errors = 0, checks = 0, cycles = 0, reqs = 0, acks = 0, dly = 0;

   assign dtack_n = dtack_oe ? 1'b0 : 1'b1;
   assign berr_n = berr_oe ? 1'b0 : 1'b1;
   always_comb
      for (int i = 0; i < 4; i++)
         d_bus[i*8 +: 8] = d_oe[i] ? d_out[i*8 +: 8] : m_d[i*8 +: 8];

   dtb_slave_response_bus_timer #(.DATA_CAP(DW_D16), .UAT_CAP(1'b0), .BTO_CYCLES(BTO))
   i_dtb_slave_response_bus_timer (.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .AS_N(as_n), .DS0_N(ds0_n),
      .DS1_N(ds1_n), .LWORD_N(lword_n), .WRITE_N(write_n), .IACK_N(iack_n), .A(a), .AM(am), .D_IN(d_bus),
      .DTACK_N_IN(dtack_n), .DTACK_N_OUT(dtack_n_out), .DTACK_OE(dtack_oe), .BERR_N_IN(berr_n),
      .BERR_N_OUT(berr_n_out), .BERR_OE(berr_oe), .D_OUT(d_out), .D_OE(d_oe), .LOC_REQ(loc_req),
      .LOC_WRITE(loc_write), .LOC_ADDR(loc_addr), .LOC_DS_N(loc_ds_n), .LOC_LWORD_N(loc_lword_n),
      .LOC_WDATA(cap_wdata), .LOC_ACK(loc_ack), .LOC_RDATA(loc_rdata), .LOC_RERR(loc_rerr));

   dtb_master_model master_m (.clk(sys_clk), .dtack_n(dtack_n), .berr_n(berr_n), .d_bus(d_bus), .as_n(as_n),
      .ds0_n(ds0_n), .ds1_n(ds1_n), .lword_n(lword_n), .write_n(write_n), .iack_n(iack_n), .a(a), .am(am),
      .d(m_d));

   ////////////////////////////////////////////////////////////////////////////////
   // Local storage answers three cycles after a request and records it.
   always @(posedge sys_clk)
   begin
      loc_ack <= 1'b0;
      if (dtack_oe)
         acks++;
      if (loc_req && !loc_ack)
      begin
         dly <= dly + 1;
         if (dly == 2)
         begin
            loc_ack <= 1'b1;
            loc_rerr <= rerr_mode;
            dly <= 0;
            reqs++;
            cap_write <= loc_write;
            cap_addr <= loc_addr;
         end
      end
   end

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic final_report;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Double byte writes in all three addressing modes.
   task automatic t_write;
      logic [31:0] rd;
      logic err;
      int n;
      logic [5:0] modes [3];
      modes = '{6'h29, 6'h39, 6'h09};
      foreach (modes[i])
      begin
         master_m.run(1'b0, 2'b00, 1'b1, 32'h0000_0010, modes[i], 1'b1, 32'h1234_abcd, rd, err, n);
         chk(32'(err), 32'h0000_0000);
         chk(32'(n < 15), 32'h0000_0001);
         chk(32'(cap_write), 32'h0000_0001);
         chk(32'(cap_addr), 32'h0000_0008);
         chk(cap_wdata, 32'h0000_abcd);
         chk(32'({loc_lword_n, loc_ds_n}), 32'h0000_0004);
         chk(32'({dtack_n_out, berr_n_out}), 32'h0000_0000);
      end
   endtask

   // Odd byte read, then a read that finds a storage error.
   task automatic t_read;
      logic [31:0] rd;
      logic err;
      int n;
      master_m.run(1'b1, 2'b10, 1'b1, 32'h0000_0020, 6'h39, 1'b1, 32'h0000_0000, rd, err, n);
      chk(32'(err), 32'h0000_0000);
      chk(rd, 32'h0000_5a3c);
      chk(32'(cap_write), 32'h0000_0000);
      chk(32'({loc_lword_n, loc_ds_n}), 32'h0000_0006);
      rerr_mode <= 1'b1;
      master_m.run(1'b1, 2'b10, 1'b1, 32'h0000_0020, 6'h39, 1'b1, 32'h0000_0000, rd, err, n);
      chk(32'(err), 32'h0000_0001);
      chk(32'(n < 15), 32'h0000_0001);
      rerr_mode <= 1'b0;
   endtask

   // Quad, triple and middle pair cycles are refused without acknowledge.
   task automatic t_reject;
      logic [31:0] rd;
      logic err;
      int n, r0, a0;
      logic [1:0] dss [3];
      logic [31:0] ads [3];
      dss = '{2'b00, 2'b10, 2'b00};
      ads = '{32'h0000_0020, 32'h0000_0020, 32'h0000_0022};
      foreach (dss[i])
      begin
         r0 = reqs;
         a0 = acks;
         master_m.run(1'b0, dss[i], 1'b0, ads[i], 6'h39, 1'b1, 32'h0000_0000, rd, err, n);
         chk(32'(err), 32'h0000_0001);
         chk(32'(n < 15), 32'h0000_0001);
         chk(32'(reqs - r0), 32'h0000_0000);
         chk(32'(acks - a0), 32'h0000_0000);
      end
   endtask

   // Two unanswered cycles in a row, outside the window and in no mode, each timed from its own strobe.
   task automatic t_timer;
      logic [31:0] rd;
      logic err;
      int n, r0;
      logic [5:0] modes [2];
      logic [31:0] ads [2];
      modes = '{6'h39, 6'h19};
      ads = '{32'h0000_1000, 32'h0000_0010};
      r0 = reqs;
      foreach (modes[i])
      begin
         master_m.run(1'b1, 2'b00, 1'b1, ads[i], modes[i], 1'b1, 32'h0000_0000, rd, err, n);
         chk(32'(err), 32'h0000_0001);
         chk(32'(n > BTO && n <= BTO + 8), 32'h0000_0001);
      end
      chk(32'(reqs - r0), 32'h0000_0000);
   endtask

   // Clock enable held low for ten cycles stretches the time-out by as much.
   task automatic t_freeze;
      logic [31:0] rd;
      logic err;
      int n;
      fork
         master_m.run(1'b1, 2'b00, 1'b1, 32'h0000_1000, 6'h39, 1'b1, 32'h0000_0000, rd, err, n);
         begin
            repeat (8) @(posedge sys_clk);
            ce <= 1'b0;
            repeat (10) @(posedge sys_clk);
            ce <= 1'b1;
         end
      join
      chk(32'(err), 32'h0000_0001);
      chk(32'(n > BTO + 10 && n <= BTO + 18), 32'h0000_0001);
   endtask

   // A cycle with interrupt acknowledge low is ignored by the slave.
   task automatic t_iack;
      logic [31:0] rd;
      logic err;
      int n, r0;
      r0 = reqs;
      master_m.run(1'b1, 2'b00, 1'b1, 32'h0000_0010, 6'h39, 1'b0, 32'h0000_0000, rd, err, n);
      chk(32'(reqs - r0), 32'h0000_0000);
      chk(32'(n > BTO), 32'h0000_0001);
   endtask

   initial
   begin
      sys_clk = 1'b0;
      forever
         #5 sys_clk = ~sys_clk;
   end

   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      rerr_mode = 1'b0;
      loc_rdata = 32'hcafe_5a3c;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      t_write();
      t_read();
      t_reject();
      t_timer();
      t_freeze();
      t_iack();
      final_report();
   end
endmodule // dtb_slave_response_bus_timer_tb_top
